// ### design/epd_regs.vh
// command codes, field positions, reset values and counts of the decoder
`ifndef EPD_REGS_VH
`define EPD_REGS_VH

// command codes
`define EPD_CMD_GATE_SCAN 8'h01
`define EPD_CMD_GATE_VOLT 8'h03
`define EPD_CMD_SRC_VOLT 8'h04
`define EPD_CMD_SCAN_START 8'h0f
`define EPD_CMD_SLEEP 8'h10
`define EPD_CMD_STEP_MODE 8'h11
`define EPD_CMD_SOFT_RESET 8'h12
`define EPD_CMD_HV_CHECK 8'h14
`define EPD_CMD_SUPPLY_CHECK 8'h15
`define EPD_CMD_TEMP_SRC 8'h18
`define EPD_CMD_TEMP_WRITE 8'h1a
`define EPD_CMD_TEMP_READ 8'h1b
`define EPD_CMD_ACTIVATE 8'h20
`define EPD_CMD_UPD_OPTION 8'h22

// reset values
`define EPD_RST_GATE_LINES 10'h2a7
`define EPD_RST_SCAN_MODE 3'h0
`define EPD_RST_GATE_VOLT 5'h00
`define EPD_RST_SRC_HIGH1 8'h41
`define EPD_RST_SRC_HIGH2 8'ha8
`define EPD_RST_SRC_LOW 8'h32
`define EPD_RST_SCAN_START 10'h000
`define EPD_RST_SLEEP 2'h0
`define EPD_RST_STEP_MODE 3'h3
`define EPD_RST_SUPPLY_LVL 3'h4
`define EPD_RST_TEMP_SRC 8'h48
`define EPD_RST_TEMP 12'h7ff
`define EPD_RST_UPD_OPT 8'hff

// highest gate line, base of reversed scan start
`define EPD_SCAN_LAST_LINE 10'h2a7

// field positions
`define EPD_BIT_FIRST_GATE 2
`define EPD_BIT_INTERLEAVE 1
`define EPD_BIT_REVERSE 0
`define EPD_BIT_AXIS 2
`define EPD_BIT_OPT_CLK_ON 7
`define EPD_BIT_OPT_ANA_ON 6
`define EPD_BIT_OPT_ANA_OFF 1
`define EPD_BIT_OPT_CLK_OFF 0

// busy durations in clock cycles
`define EPD_SWRST_CYCLES 12'h040
`define EPD_DETECT_CYCLES 12'h080
`define EPD_ACT_CYCLES 12'h020

`endif

// ### design/epd_sync.v
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module epd_sync #(
  parameter WIDTH = 1
) (
  // clock, reset, enable
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  // asynchronous levels and their synchronised copies
  input wire [WIDTH-1:0] d_in,
  output reg [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] stage1;

  ////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1 <= {WIDTH{1'b0}};
      q_out <= {WIDTH{1'b0}};
    end else if (ce_in) begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end

endmodule // epd_sync

// ### design/epd_cmd_decoder.v
// serial command decoder of the panel driver: settings, sleep, busy
`include "epd_regs.vh"
`timescale 1ns/1ps
module epd_cmd_decoder #(
  parameter [11:0] SWRST_CYCLES = `EPD_SWRST_CYCLES,
  parameter [11:0] DETECT_CYCLES = `EPD_DETECT_CYCLES,
  parameter [11:0] ACT_CYCLES = `EPD_ACT_CYCLES
) (
  // clock, reset, enable
  input wire CLK_IN,
  input wire NRST_IN,
  input wire CE_IN,
  // serial host pins
  input wire CS_N_IN,
  input wire SCL_IN,
  input wire DC_IN,
  input wire WIRE3_SEL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE_OUT,
  output wire BUSY_OUT,
  // gate settings
  output reg [9:0] GATE_LINES_OUT,
  output reg FIRST_GATE_SELECT_OUT,
  output reg INTERLEAVE_SCAN_OUT,
  output reg SCAN_REVERSE_OUT,
  output reg [4:0] GATE_VOLT_OUT,
  output reg [9:0] SCAN_START_LINE_OUT,
  // source levels
  output reg [7:0] SOURCE_HIGH_LEVEL_ONE_OUT,
  output reg [7:0] SOURCE_HIGH_LEVEL_TWO_OUT,
  output reg [7:0] SOURCE_LOW_LEVEL_OUT,
  // sleep and address stepping
  output reg [1:0] SLEEP_MODE_OUT,
  output reg [1:0] ADDRESS_STEP_DIRECTION_OUT,
  output reg ADDRESS_AXIS_SELECT_OUT,
  // detection and temperature
  output reg [2:0] SUPPLY_LEVEL_OUT,
  output reg HV_CHECK_RUN_OUT,
  output reg SUPPLY_CHECK_RUN_OUT,
  output reg [7:0] TEMP_SOURCE_OUT,
  output reg [11:0] TEMPERATURE_OUT,
  // power flags
  output reg OSC_CLOCK_ON_OUT,
  output reg ANALOG_SECTION_ON_OUT
);

  localparam ST_READY = 2'b00;
  localparam ST_BUSY = 2'b01;
  localparam ST_SLEEP = 2'b10;

  wire sel_s;
  wire scl_s;
  wire dc_s;
  wire wire3_s;
  wire sda_s;
  reg scl_d;
  reg [3:0] bit_cnt;
  reg [6:0] shreg;
  reg dc_bit;
  reg [7:0] cmd;
  reg [2:0] pidx;
  reg [7:0] tx;
  reg rd_active;
  reg [1:0] state;
  reg [11:0] busy_cnt;
  reg [9:0] scan_value;
  reg [7:0] upd_opt;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; all five share one latency so they stay aligned
  epd_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .ce_in(CE_IN),
    .d_in({~CS_N_IN, SCL_IN, DC_IN, WIRE3_SEL_IN, SDA_IN}),
    .q_out({sel_s, scl_s, dc_s, wire3_s, sda_s})
  );
  // select synced active high, so reset reads as deselected like the pin
  wire cs_n_s = ~sel_s;

  ////////////////////////////////////////////////////////////////////////
  // byte framing on sampled serial clock
  wire scl_rise = scl_s & ~scl_d & ~cs_n_s;
  wire [3:0] last_bit = wire3_s ? 4'h8 : 4'h7;
  wire byte_done = scl_rise & (bit_cnt == last_bit);
  wire [7:0] byte_val = {shreg, sda_s};
  // in 3-wire mode the select travels as the leading bit
  wire is_cmd = ~(wire3_s ? dc_bit : dc_s);
  wire ready = (state == ST_READY);
  wire take = byte_done & ready;
  wire take_cmd = take & is_cmd;
  wire take_par = take & ~is_cmd;
  wire power_ok = OSC_CLOCK_ON_OUT & ANALOG_SECTION_ON_OUT;
  wire hv_start = take_cmd & (byte_val == `EPD_CMD_HV_CHECK) & power_ok;
  wire sup_start = take_par & (cmd == `EPD_CMD_SUPPLY_CHECK) &
                   (pidx == 3'h0) & power_ok;
  wire busy_end = (state == ST_BUSY) & (busy_cnt == 12'h001);

  // reads only in 4-wire mode; the 3-wire read format is not supported
  assign SDA_OUT = tx[7];
  assign SDA_OE_OUT = rd_active;
  assign BUSY_OUT = (state != ST_READY);

  ////////////////////////////////////////////////////////////////////////
  // serial shift register, bit counter, select bit
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      scl_d <= 1'b0;
      bit_cnt <= 4'h0;
      shreg <= 7'h00;
      dc_bit <= 1'b0;
    end else if (CE_IN) begin
      scl_d <= scl_s;
      if (cs_n_s) begin
        bit_cnt <= 4'h0;
      end else if (byte_done) begin
        bit_cnt <= 4'h0;
      end else if (scl_rise) begin
        bit_cnt <= bit_cnt + 4'h1;
        if (wire3_s && bit_cnt == 4'h0) begin
          dc_bit <= sda_s;
        end else begin
          shreg <= byte_val[6:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // current command and parameter index
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cmd <= 8'h00;
      pidx <= 3'h0;
    end else if (CE_IN) begin
      if (take_cmd) begin
        cmd <= byte_val;
        pidx <= 3'h0;
      end else if (take_par && pidx != 3'h7) begin
        pidx <= pidx + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read-back of the temperature register, shifted on rising edges
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx <= 8'h00;
      rd_active <= 1'b0;
    end else if (CE_IN) begin
      rd_active <= (cmd == `EPD_CMD_TEMP_READ) & dc_s & ~cs_n_s &
                   ~wire3_s & ready;
      if (take_cmd && byte_val == `EPD_CMD_TEMP_READ) begin
        tx <= TEMPERATURE_OUT[11:4];
      end else if (take_par && cmd == `EPD_CMD_TEMP_READ) begin
        // second byte carries the low nibble, then zeros
        tx <= (pidx == 3'h0) ? {TEMPERATURE_OUT[3:0], 4'h0} : 8'h00;
      end else if (scl_rise && rd_active) begin
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operating state and busy timer
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state <= ST_READY;
      busy_cnt <= 12'h000;
    end else if (CE_IN) begin
      case (state)
        ST_READY: begin
          if (take_par && cmd == `EPD_CMD_SLEEP && byte_val[1:0] != 2'h0) begin
            state <= ST_SLEEP;
          end else if (take_cmd && byte_val == `EPD_CMD_SOFT_RESET) begin
            state <= ST_BUSY;
            busy_cnt <= SWRST_CYCLES;
          end else if (take_cmd && byte_val == `EPD_CMD_HV_CHECK &&
                       power_ok) begin
            state <= ST_BUSY;
            busy_cnt <= DETECT_CYCLES;
          end else if (take_par && cmd == `EPD_CMD_SUPPLY_CHECK &&
                       pidx == 3'h0 && power_ok) begin
            state <= ST_BUSY;
            busy_cnt <= DETECT_CYCLES;
          end else if (take_cmd && byte_val == `EPD_CMD_ACTIVATE) begin
            state <= ST_BUSY;
            busy_cnt <= ACT_CYCLES;
          end
        end
        ST_BUSY: begin
          if (busy_cnt == 12'h001) begin
            state <= ST_READY;
          end
          busy_cnt <= busy_cnt - 12'h001;
        end
        // no serial byte is taken here; only the hardware reset leaves
        ST_SLEEP: state <= ST_SLEEP;
        default: state <= ST_READY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // detection run flags, set and cleared on the same edges as busy
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      HV_CHECK_RUN_OUT <= 1'b0;
      SUPPLY_CHECK_RUN_OUT <= 1'b0;
    end else if (CE_IN) begin
      if (hv_start) begin
        HV_CHECK_RUN_OUT <= 1'b1;
      end else if (busy_end) begin
        HV_CHECK_RUN_OUT <= 1'b0;
      end
      if (sup_start) begin
        SUPPLY_CHECK_RUN_OUT <= 1'b1;
      end else if (busy_end) begin
        SUPPLY_CHECK_RUN_OUT <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan start line; reversed scan counts down from the last line
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      SCAN_START_LINE_OUT <= `EPD_RST_SCAN_START;
    end else if (CE_IN) begin
      SCAN_START_LINE_OUT <= SCAN_REVERSE_OUT ?
                             `EPD_SCAN_LAST_LINE - scan_value :
                             scan_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power flags: the activation command moves them, the soft reset clears them
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      OSC_CLOCK_ON_OUT <= 1'b0;
      ANALOG_SECTION_ON_OUT <= 1'b0;
    end else if (CE_IN) begin
      if (take_cmd && byte_val == `EPD_CMD_ACTIVATE) begin
        // a sequence that switches off at its end leaves the flag low
        OSC_CLOCK_ON_OUT <= (OSC_CLOCK_ON_OUT |
                             upd_opt[`EPD_BIT_OPT_CLK_ON]) &
                            ~upd_opt[`EPD_BIT_OPT_CLK_OFF];
        ANALOG_SECTION_ON_OUT <= (ANALOG_SECTION_ON_OUT |
                                  upd_opt[`EPD_BIT_OPT_ANA_ON]) &
                                 ~upd_opt[`EPD_BIT_OPT_ANA_OFF];
      end else if (take_cmd && byte_val == `EPD_CMD_SOFT_RESET) begin
        OSC_CLOCK_ON_OUT <= 1'b0;
        ANALOG_SECTION_ON_OUT <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sleep setting survives the soft reset
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      SLEEP_MODE_OUT <= `EPD_RST_SLEEP;
    end else if (CE_IN) begin
      if (take_par && cmd == `EPD_CMD_SLEEP && pidx == 3'h0) begin
        SLEEP_MODE_OUT <= byte_val[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parameter store; soft reset restores it, display memory is elsewhere
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      GATE_LINES_OUT <= `EPD_RST_GATE_LINES;
      {FIRST_GATE_SELECT_OUT, INTERLEAVE_SCAN_OUT, SCAN_REVERSE_OUT} <=
        `EPD_RST_SCAN_MODE;
      GATE_VOLT_OUT <= `EPD_RST_GATE_VOLT;
      SOURCE_HIGH_LEVEL_ONE_OUT <= `EPD_RST_SRC_HIGH1;
      SOURCE_HIGH_LEVEL_TWO_OUT <= `EPD_RST_SRC_HIGH2;
      SOURCE_LOW_LEVEL_OUT <= `EPD_RST_SRC_LOW;
      scan_value <= `EPD_RST_SCAN_START;
      {ADDRESS_AXIS_SELECT_OUT, ADDRESS_STEP_DIRECTION_OUT} <=
        `EPD_RST_STEP_MODE;
      SUPPLY_LEVEL_OUT <= `EPD_RST_SUPPLY_LVL;
      TEMP_SOURCE_OUT <= `EPD_RST_TEMP_SRC;
      TEMPERATURE_OUT <= `EPD_RST_TEMP;
      upd_opt <= `EPD_RST_UPD_OPT;
    end else if (CE_IN) begin
      if (take_cmd && byte_val == `EPD_CMD_SOFT_RESET) begin
        GATE_LINES_OUT <= `EPD_RST_GATE_LINES;
        {FIRST_GATE_SELECT_OUT, INTERLEAVE_SCAN_OUT, SCAN_REVERSE_OUT} <=
          `EPD_RST_SCAN_MODE;
        GATE_VOLT_OUT <= `EPD_RST_GATE_VOLT;
        SOURCE_HIGH_LEVEL_ONE_OUT <= `EPD_RST_SRC_HIGH1;
        SOURCE_HIGH_LEVEL_TWO_OUT <= `EPD_RST_SRC_HIGH2;
        SOURCE_LOW_LEVEL_OUT <= `EPD_RST_SRC_LOW;
        scan_value <= `EPD_RST_SCAN_START;
        {ADDRESS_AXIS_SELECT_OUT, ADDRESS_STEP_DIRECTION_OUT} <=
          `EPD_RST_STEP_MODE;
        SUPPLY_LEVEL_OUT <= `EPD_RST_SUPPLY_LVL;
        TEMP_SOURCE_OUT <= `EPD_RST_TEMP_SRC;
        TEMPERATURE_OUT <= `EPD_RST_TEMP;
        upd_opt <= `EPD_RST_UPD_OPT;
      end else if (take_par) begin
        case (cmd)
          `EPD_CMD_GATE_SCAN: begin
            if (pidx == 3'h0) begin
              GATE_LINES_OUT[7:0] <= byte_val;
            end else if (pidx == 3'h1) begin
              GATE_LINES_OUT[9:8] <= byte_val[1:0];
            end else if (pidx == 3'h2) begin
              FIRST_GATE_SELECT_OUT <= byte_val[`EPD_BIT_FIRST_GATE];
              INTERLEAVE_SCAN_OUT <= byte_val[`EPD_BIT_INTERLEAVE];
              SCAN_REVERSE_OUT <= byte_val[`EPD_BIT_REVERSE];
            end
          end
          `EPD_CMD_GATE_VOLT: begin
            if (pidx == 3'h0) begin
              GATE_VOLT_OUT <= byte_val[4:0];
            end
          end
          `EPD_CMD_SRC_VOLT: begin
            if (pidx == 3'h0) begin
              SOURCE_HIGH_LEVEL_ONE_OUT <= byte_val;
            end else if (pidx == 3'h1) begin
              SOURCE_HIGH_LEVEL_TWO_OUT <= byte_val;
            end else if (pidx == 3'h2) begin
              SOURCE_LOW_LEVEL_OUT <= byte_val;
            end
          end
          `EPD_CMD_SCAN_START: begin
            if (pidx == 3'h0) begin
              scan_value[7:0] <= byte_val;
            end else if (pidx == 3'h1) begin
              scan_value[9:8] <= byte_val[1:0];
            end
          end
          `EPD_CMD_STEP_MODE: begin
            if (pidx == 3'h0) begin
              ADDRESS_STEP_DIRECTION_OUT <= byte_val[1:0];
              ADDRESS_AXIS_SELECT_OUT <= byte_val[`EPD_BIT_AXIS];
            end
          end
          `EPD_CMD_SUPPLY_CHECK: begin
            if (pidx == 3'h0) begin
              SUPPLY_LEVEL_OUT <= byte_val[2:0];
            end
          end
          `EPD_CMD_TEMP_SRC: begin
            if (pidx == 3'h0) begin
              TEMP_SOURCE_OUT <= byte_val;
            end
          end
          `EPD_CMD_TEMP_WRITE: begin
            if (pidx == 3'h0) begin
              TEMPERATURE_OUT[11:4] <= byte_val;
            end else if (pidx == 3'h1) begin
              TEMPERATURE_OUT[3:0] <= byte_val[7:4];
            end
          end
          `EPD_CMD_UPD_OPTION: begin
            if (pidx == 3'h0) begin
              upd_opt <= byte_val;
            end
          end
          // unknown commands and surplus bytes fall through unused
          default: upd_opt <= upd_opt;
        endcase
      end
    end
  end

endmodule // epd_cmd_decoder

// ### test/epd_cmd_props_properties.sv
// checker of busy, sleep, detection and scan start at the decoder pins
`timescale 1ns/1ps
module epd_cmd_props #(
  parameter [11:0] SWRST_CYCLES = 12'h040,
  parameter [11:0] DETECT_CYCLES = 12'h080,
  parameter [11:0] ACT_CYCLES = 12'h020
) (
  // clock, reset, mode
  input wire CLK_IN,
  input wire NRST_IN,
  input wire WIRE3_SEL_IN,
  // watched outputs
  input wire SDA_OE_OUT,
  input wire BUSY_OUT,
  input wire SCAN_REVERSE_OUT,
  input wire [9:0] SCAN_START_LINE_OUT,
  input wire [4:0] GATE_VOLT_OUT,
  input wire [11:0] TEMPERATURE_OUT,
  input wire [1:0] SLEEP_MODE_OUT,
  input wire HV_CHECK_RUN_OUT,
  input wire SUPPLY_CHECK_RUN_OUT,
  input wire OSC_CLOCK_ON_OUT,
  input wire ANALOG_SECTION_ON_OUT
);
  reg [11:0] busy_run;
  // length of the busy window in progress
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN)
      busy_run <= 12'h000;
    else if (BUSY_OUT)
      busy_run <= busy_run + 12'h001;
    else
      busy_run <= 12'h000;
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  property p_sleep_busy;
    SLEEP_MODE_OUT != 2'h0 |-> BUSY_OUT;
  endproperty
  a_sleep_busy: assert property (p_sleep_busy)
    else $error("busy low while asleep");
  property p_sleep_hold;
    SLEEP_MODE_OUT != 2'h0 |=> SLEEP_MODE_OUT == $past(SLEEP_MODE_OUT);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("left sleep without reset");
  property p_hv_busy;
    HV_CHECK_RUN_OUT |-> BUSY_OUT && !SUPPLY_CHECK_RUN_OUT;
  endproperty
  a_hv_busy: assert property (p_hv_busy)
    else $error("hv check without busy");
  property p_hv_power;
    $rose(HV_CHECK_RUN_OUT) |-> OSC_CLOCK_ON_OUT && ANALOG_SECTION_ON_OUT;
  endproperty
  a_hv_power: assert property (p_hv_power)
    else $error("hv check started unpowered");
  property p_supply_run;
    $rose(SUPPLY_CHECK_RUN_OUT) |-> BUSY_OUT && OSC_CLOCK_ON_OUT
      && ANALOG_SECTION_ON_OUT;
  endproperty
  a_supply_run: assert property (p_supply_run)
    else $error("supply check started badly");
  // a reverse flip alone mirrors the start line about 679
  property p_scan_mirror;
    $changed(SCAN_REVERSE_OUT) && !BUSY_OUT |=>
      SCAN_START_LINE_OUT == 10'd679 - $past(SCAN_START_LINE_OUT);
  endproperty
  a_scan_mirror: assert property (p_scan_mirror)
    else $error("scan start not mirrored");
  property p_busy_freeze;
    BUSY_OUT && $past(BUSY_OUT) |-> $stable(GATE_VOLT_OUT)
      && $stable(TEMPERATURE_OUT);
  endproperty
  a_busy_freeze: assert property (p_busy_freeze)
    else $error("setting changed while busy");
  property p_busy_len;
    $fell(BUSY_OUT) |-> busy_run == SWRST_CYCLES
      || busy_run == DETECT_CYCLES || busy_run == ACT_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy window of wrong length");
  property p_read_4wire;
    SDA_OE_OUT |-> !WIRE3_SEL_IN && !BUSY_OUT;
  endproperty
  a_read_4wire: assert property (p_read_4wire)
    else $error("data line driven out of a read");
endmodule // epd_cmd_props

bind epd_cmd_decoder epd_cmd_props #(.SWRST_CYCLES(SWRST_CYCLES),
  .DETECT_CYCLES(DETECT_CYCLES), .ACT_CYCLES(ACT_CYCLES)) i_props (
  .CLK_IN, .NRST_IN, .WIRE3_SEL_IN, .SDA_OE_OUT, .BUSY_OUT,
  .SCAN_REVERSE_OUT, .SCAN_START_LINE_OUT, .GATE_VOLT_OUT,
  .TEMPERATURE_OUT, .SLEEP_MODE_OUT, .HV_CHECK_RUN_OUT,
  .SUPPLY_CHECK_RUN_OUT, .OSC_CLOCK_ON_OUT, .ANALOG_SECTION_ON_OUT);

// ### test/epd_host_model.sv
// host model: serial master sending command and parameter bytes
`timescale 1ns/1ps
module epd_host_model (
  // clock and mode
  input wire clk_in,
  input wire wire3_in,
  // resolved data line
  input wire sda_in,
  // pins towards the device
  output logic cs_n_out,
  output logic scl_out,
  output logic dc_out,
  output logic sda_out
);
  // link clock stands low outside frames
  initial begin
    cs_n_out = 1'b1;
    scl_out = 1'b0;
    dc_out = 1'b0;
    sda_out = 1'b0;
  end
  // step just past an edge so pins never move on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic open_frame();
    cs_n_out = 1'b0;
    tick(4);
  endtask
  task automatic close_frame();
    tick(4);
    cs_n_out = 1'b1;
    tick(6);
  endtask
  // one unit msb first, 80 ns period; 3-wire leads with the select bit
  task automatic xfer(input logic dc, input logic [7:0] d,
                      output logic [7:0] rd);
    logic [8:0] v;
    v = {dc, d};
    dc_out = dc;
    tick(6);
    for (int i = (wire3_in ? 8 : 7); i >= 0; i--) begin
      sda_out = v[i];
      tick(4);
      scl_out = 1'b1;
      rd = {rd[6:0], sda_in};
      tick(4);
      scl_out = 1'b0;
    end
    // released line shows the inverse, not a held value
    sda_out = ~sda_out;
  endtask
endmodule // epd_host_model

// ### test/epd_cmd_decoder_tb.sv
// self-checking bench of the serial command decoder
`timescale 1ns/1ps
module epd_cmd_decoder_tb;
  logic CLK_IN, NRST_IN, CE_IN, WIRE3_SEL_IN;
  wire cs_n, scl, dc, host_sda, sda_out, sda_oe, busy;
  wire [9:0] lines, start;
  wire fg, il, rv, axis, hv, sup, osc, ana;
  wire [4:0] gv;
  wire [7:0] sh1, sh2, sl, tsrc;
  wire [1:0] slp, dir;
  wire [2:0] lvl;
  wire [11:0] temp;
  int num_errors = 0;
  int n_checks = 0;
  // device drives the line only while enabled
  wire sda_line = sda_oe ? sda_out : host_sda;

  epd_cmd_decoder #(.SWRST_CYCLES(12'd40), .DETECT_CYCLES(12'd60),
    .ACT_CYCLES(12'd30)) i_dut (
    .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN), .CS_N_IN(cs_n),
    .SCL_IN(scl), .DC_IN(dc), .WIRE3_SEL_IN(WIRE3_SEL_IN),
    .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe),
    .BUSY_OUT(busy), .GATE_LINES_OUT(lines), .FIRST_GATE_SELECT_OUT(fg),
    .INTERLEAVE_SCAN_OUT(il), .SCAN_REVERSE_OUT(rv), .GATE_VOLT_OUT(gv),
    .SCAN_START_LINE_OUT(start), .SOURCE_HIGH_LEVEL_ONE_OUT(sh1),
    .SOURCE_HIGH_LEVEL_TWO_OUT(sh2), .SOURCE_LOW_LEVEL_OUT(sl),
    .SLEEP_MODE_OUT(slp), .ADDRESS_STEP_DIRECTION_OUT(dir),
    .ADDRESS_AXIS_SELECT_OUT(axis), .SUPPLY_LEVEL_OUT(lvl),
    .HV_CHECK_RUN_OUT(hv), .SUPPLY_CHECK_RUN_OUT(sup),
    .TEMP_SOURCE_OUT(tsrc), .TEMPERATURE_OUT(temp),
    .OSC_CLOCK_ON_OUT(osc), .ANALOG_SECTION_ON_OUT(ana));
  epd_host_model i_host (.clk_in(CLK_IN), .wire3_in(WIRE3_SEL_IN),
    .sda_in(sda_line), .cs_n_out(cs_n), .scl_out(scl), .dc_out(dc),
    .sda_out(host_sda));

  initial begin
    CLK_IN = 1'b0;
    forever #5 CLK_IN = ~CLK_IN;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic hw_reset();
    NRST_IN = 1'b0;
    repeat (12) @(posedge CLK_IN);
    #1;
    NRST_IN = 1'b1;
    repeat (4) @(posedge CLK_IN);
    #1;
  endtask
  // command with up to four parameter bytes, first byte in p[31:24]
  task automatic send(input logic [7:0] c, input int n,
                      input logic [31:0] p);
    logic [7:0] rd;
    i_host.open_frame();
    i_host.xfer(1'b0, c, rd);
    for (int i = 0; i < n; i++)
      i_host.xfer(1'b1, p[31-8*i -: 8], rd);
    i_host.close_frame();
  endtask
  // bounded wait for the busy window to close
  task automatic idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 300) begin
      @(posedge CLK_IN);
      k++;
    end
    #1;
    chk(k < 300, 1);
  endtask
  initial begin
    #600000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] rd;
    logic [31:0] codes;
    codes = 32'h00071617;
    NRST_IN = 1'b0;
    CE_IN = 1'b1;
    WIRE3_SEL_IN = 1'b0;
    hw_reset();
    chk(lines, 32'h2a7);
    chk({fg, il, rv}, 32'h0);
    chk({sh1, sh2, sl}, 32'h41a832);
    chk({axis, dir}, 32'h3);
    chk({lvl, tsrc, temp}, 32'h4487ff);
    chk({osc, ana, busy, sda_oe}, 32'h0);
    send(8'h01, 4, 32'h550107ff);
    chk({lines, fg, il, rv}, {19'h0, 10'h155, 3'h7});
    send(8'h01, 1, 32'haa000000);
    chk({lines, fg, il, rv}, {19'h0, 10'h1aa, 3'h7});
    send(8'h0f, 2, 32'h10000000);
    chk(start, 32'h297);
    send(8'h01, 3, 32'haa0100ff);
    chk(start, 32'h010);
    for (int i = 0; i < 4; i++) begin
      send(8'h03, 1, {codes[31-8*i -: 8], 24'h0});
      chk(gv, {24'h0, codes[31-8*i -: 8]});
    end
    send(8'h04, 3, 32'h238e1a00);
    chk({sh1, sh2, sl}, 32'h238e1a);
    for (int v = 0; v < 8; v++) begin
      send(8'h11, 1, v << 24);
      chk({axis, dir}, v);
    end
    send(8'h18, 1, 32'h0);
    chk(tsrc, 32'h0);
    send(8'h1a, 2, 32'habc00000);
    chk(temp, 32'habc);
    i_host.open_frame();
    i_host.xfer(1'b0, 8'h1b, rd);
    i_host.xfer(1'b1, 8'h00, rd);
    chk(rd, 32'hab);
    i_host.xfer(1'b1, 8'h00, rd);
    chk(rd, 32'hc0);
    i_host.close_frame();
    WIRE3_SEL_IN = 1'b1;
    send(8'h03, 1, 32'h0c000000);
    chk(gv, 32'h0c);
    WIRE3_SEL_IN = 1'b0;
    send(8'h15, 1, 32'h07000000);
    chk({lvl, busy}, 32'he);
    send(8'h14, 0, 32'h0);
    chk({hv, busy}, 32'h0);
    send(8'h22, 1, 32'hc0000000);
    send(8'h20, 0, 32'h0);
    chk({osc, ana, busy}, 32'h7);
    idle();
    send(8'h14, 0, 32'h0);
    chk({hv, busy}, 32'h3);
    idle();
    send(8'h15, 1, 32'h05000000);
    chk({sup, busy, lvl}, 32'h1d);
    idle();
    send(8'h12, 0, 32'h0);
    chk({busy, osc, lines, gv, temp},
        {3'h0, 2'h2, 10'h2a7, 5'h00, 12'h7ff});
    chk({lvl, tsrc, dir, axis}, {18'h0, 3'h4, 8'h48, 3'h6});
    idle();
    for (int i = 0; i < 3; i++) begin
      send(8'h10, 1, (i == 2 ? 32'h3 : i) << 24);
      chk({slp, busy}, (i == 2) ? 32'h7 : {29'h0, i[1:0], i[0]});
      send(8'h12, 0, 32'h0);
      chk(slp, (i == 2) ? 32'h3 : i);
      hw_reset();
      chk({slp, busy}, 32'h0);
    end
    tally_and_finish();
  end
endmodule // epd_cmd_decoder_tb
